// ### hw/lowspeed_usb_endpoint_ctrl.sv
`timescale 1ns/10ps
`include "usb_ep_consts.svh"
// Overview of operation
// R1: Endpoint-zero data is stored, then status updated, then the event raised.
// R2: Any write to receive status clears all bits but the toggle and, during SETUP data, the SETUP flag.
// R3: SETUP sets flag; write-protected during SETUP data; blocks firmware buffer writes.
// R4: Each endpoint-zero OUT or IN token sets OUT-seen or IN-seen, clearing the other; SETUP clears both.
// R5: Toggle captured after SETUP, or after OUT when not stalled and enabled.
// R6: Length field holds received data bytes plus two CRC bytes.
// R7: Length updated for SETUP data, and for enabled unstalled OUT data.
// R8: OUT data stored only with acceptance set, stall and auto reply clear.
// R9: At most eight bytes stored; CRC stored when fewer data bytes.
// R10: Errored or over-long data packets get no handshake.
// R11: SETUP and accepted OUT get ACK; idle OUT NAK; stalled OUT STALL.
// R12: Auto reply: status OUT ACK, other OUT STALL; errored updates toggle only.
// R13: Transmit byte count is four bits; firmware programs zero to eight.
// R14: Data error during SETUP or OUT phase sets the receive-invalid flag.
// R15: Endpoint-zero stall answers IN and OUT with STALL; SETUP clears it.
// R16: Toggle-select picks DATA0 or DATA1 for transmitted data.
// R17: IN is answered with data only while armed.
// R18: Host ACK clears endpoint-zero armed and raises event; SETUP clears armed.
// R19: Endpoint one transmits only, from buffer 0x78 to 0x7F.
// R20: Endpoint one disabled ignores all its traffic.
// R21: Endpoint-one stall answers IN and OUT with STALL until cleared.
// R22: Host ACK clears endpoint-one armed and raises its event.
// R23: Endpoint zero shares one buffer 0x70 to 0x77 for both directions.
// R24: Acceptance cleared after SETUP or ACKed OUT, not after NAKed OUT.
// R25: Status OUT is DATA1 with no data; SETUP clears auto reply.
module lowspeed_usb_endpoint_ctrl #(
	parameter int FIFO_WIDTH = 8,
	parameter int FIFO_DEPTH = 2
) (
	// Clock and reset.
	input  wire logic                 core_clk,
	input  wire logic                 resetn,
	// Firmware I/O register port.
	input  wire logic [7:0]           io_addr,
	input  wire logic                 io_wr,
	input  wire logic [7:0]           io_wdata,
	output logic      [7:0]           io_rdata,
	// Firmware data memory port for the endpoint buffers.
	input  wire logic [7:0]           buf_addr,
	input  wire logic                 buf_wr,
	input  wire logic [7:0]           buf_wdata,
	output logic      [7:0]           buf_rdata,
	// Decoded tokens from the bus protocol engine.
	input  wire logic                 tok_valid,
	input  wire usb_ep_pkg::tok_t     tok_type,
	input  wire logic                 tok_ep,
	// Received data stream, CRC bytes included.
	input  wire logic                 rx_byte_valid,
	input  wire logic [FIFO_WIDTH-1:0] rx_byte,
	output logic                      rx_byte_ready,
	input  wire logic                 rx_end,
	input  wire logic                 rx_err,
	input  wire logic                 rx_pid_one,
	// Handshake request to the engine.
	output logic                      hs_valid,
	output usb_ep_pkg::hs_t           hs_code,
	// Transmit request and buffer fetch.
	output logic                      tx_start,
	output logic                      tx_ep,
	output logic                      tx_pid_one,
	output logic      [3:0]           tx_len,
	input  wire logic [3:0]           tx_rd_addr,
	output logic      [7:0]           tx_rd_data,
	input  wire logic                 host_ack,
	// Endpoint events.
	output logic                      ep0_event,
	output logic                      ep1_event
);

	localparam int PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
	localparam int CNT_W = $clog2(FIFO_DEPTH + 1);

	logic [7:0]             ep0_tx;
	logic [7:0]             ep1_tx;
	logic [7:0]             ep0_rx;
	logic [7:0]             usb_ctrl;
	logic [7:0]             ep_buf [16];
	usb_ep_pkg::state_t     state;
	logic                   cur_setup;
	logic                   cur_store;
	logic [3:0]             rx_count;
	logic [3:0]             wr_idx;
	logic                   pkt_err;
	logic                   pkt_crc_err;
	logic                   pkt_pid_one;
	logic                   tx_pend;
	logic                   tx_pend_ep;
	logic                   ev0_pend;
	logic                   ev1_pend;
	logic [FIFO_WIDTH-1:0]  fifo_mem [FIFO_DEPTH];
	logic [PTR_W-1:0]       fifo_wp;
	logic [PTR_W-1:0]       fifo_rp;
	logic [CNT_W-1:0]       fifo_cnt;

	// Decoded events of this cycle.
	logic tok0;
	logic tok1;
	logic setup0;
	logic fw_buf_hit;
	logic fw_buf_wr;
	logic fifo_push;
	logic fifo_pop;
	logic rx_write_hit;
	logic setup_locked;
	logic stall0;
	logic accept;
	logic auto_reply;
	logic status_ok;
	logic upd_toggle;
	logic upd_count;
	logic ack0;
	logic ack1;
	usb_ep_pkg::hs_t next_hs;
	logic next_hs_valid;
	logic next_tx_start;
	logic next_tx_ep;

	assign tok0         = tok_valid && !tok_ep;
	assign tok1         = tok_valid && tok_ep && ep1_tx[`TX_EP1_ON_BIT]; // R20
	assign setup0       = tok0 && tok_type == usb_ep_pkg::TOK_SETUP;
	assign fw_buf_hit   = buf_addr[7:4] == `BUF_REGION;
	assign fw_buf_wr    = buf_wr && fw_buf_hit && !ep0_rx[`RX_SETUP_BIT]; // R3
	assign rx_write_hit = io_wr && io_addr == `EP0_RX_OFS;
	assign setup_locked = state != usb_ep_pkg::ST_IDLE && cur_setup;
	assign stall0       = ep0_tx[`TX_STALL_BIT];
	assign accept       = usb_ctrl[`CTRL_ACCEPT_BIT];
	assign auto_reply   = usb_ctrl[`CTRL_AUTO_BIT];
	assign status_ok    = pkt_pid_one && rx_count == `CRC_BYTES; // R25
	assign ack0         = host_ack && tx_pend && !tx_pend_ep;
	assign ack1         = host_ack && tx_pend && tx_pend_ep;

	// Firmware writes take the memory first, so the buffer drain stalls for that cycle.
	assign fifo_push     = rx_byte_valid && rx_byte_ready;
	assign fifo_pop      = fifo_cnt != '0 && !fw_buf_wr;
	assign rx_byte_ready = fifo_cnt != CNT_W'(FIFO_DEPTH);

	// Table of replies and updates for data following SETUP or OUT on endpoint zero.
	always_comb begin
		upd_toggle = 1'b0;
		upd_count  = 1'b0;
		next_hs    = usb_ep_pkg::HS_NONE;
		if (cur_setup) begin
			upd_toggle = 1'b1; // R5
			upd_count  = 1'b1; // R7
			next_hs    = usb_ep_pkg::HS_ACK; // R11
		end else if (stall0) begin
			next_hs = usb_ep_pkg::HS_STALL; // R15
		end else if (auto_reply) begin
			upd_toggle = 1'b1; // R12
			upd_count  = !pkt_err;
			next_hs    = status_ok ? usb_ep_pkg::HS_ACK : usb_ep_pkg::HS_STALL; // R12
		end else if (accept) begin
			upd_toggle = 1'b1;
			upd_count  = 1'b1;
			next_hs    = usb_ep_pkg::HS_ACK; // R11
		end else begin
			next_hs = usb_ep_pkg::HS_NAK; // R11
		end
		if (pkt_err) begin
			next_hs = usb_ep_pkg::HS_NONE; // R10
		end
	end

	// Immediate answers to IN tokens and endpoint-one OUT tokens, and the deferred answer after a data packet.
	always_comb begin
		next_hs_valid = 1'b0;
		next_tx_start = 1'b0;
		next_tx_ep    = 1'b0;
		if (state == usb_ep_pkg::ST_UPDATE) begin
			next_hs_valid = next_hs != usb_ep_pkg::HS_NONE; // R10
		end else if (tok0 && tok_type == usb_ep_pkg::TOK_IN) begin
			next_hs_valid = stall0 || !ep0_tx[`TX_ARMED_BIT];
			next_tx_start = !stall0 && ep0_tx[`TX_ARMED_BIT]; // R17
		end else if (tok1 && tok_type == usb_ep_pkg::TOK_IN) begin
			next_hs_valid = ep1_tx[`TX_STALL_BIT] || !ep1_tx[`TX_ARMED_BIT];
			next_tx_start = !ep1_tx[`TX_STALL_BIT] && ep1_tx[`TX_ARMED_BIT]; // R21
			next_tx_ep    = 1'b1;
		end else if (tok1 && tok_type == usb_ep_pkg::TOK_OUT) begin
			next_hs_valid = ep1_tx[`TX_STALL_BIT]; // R21
		end
	end

	// Handshake request outputs to the engine.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			hs_valid <= 1'b0;
			hs_code  <= usb_ep_pkg::HS_NONE;
		end else begin
			hs_valid <= next_hs_valid;
			if (state == usb_ep_pkg::ST_UPDATE) begin
				hs_code <= next_hs;
			end else if (tok_ep) begin
				hs_code <= ep1_tx[`TX_STALL_BIT] ? usb_ep_pkg::HS_STALL : usb_ep_pkg::HS_NAK;
			end else begin
				hs_code <= stall0 ? usb_ep_pkg::HS_STALL : usb_ep_pkg::HS_NAK;
			end
		end
	end

	// Transmit start carries the byte count and the toggle picked by firmware.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			tx_start   <= 1'b0;
			tx_ep      <= 1'b0;
			tx_pid_one <= 1'b0;
			tx_len     <= 4'h0;
		end else begin
			tx_start <= next_tx_start; // R17
			if (next_tx_start) begin
				tx_ep      <= next_tx_ep;
				tx_pid_one <= next_tx_ep ? ep1_tx[`TX_PID_BIT] : ep0_tx[`TX_PID_BIT]; // R16
				tx_len     <= next_tx_ep ? ep1_tx[3:0] : ep0_tx[3:0]; // R13
			end
		end
	end

	// A sent packet waits for the host ACK; any new token abandons the wait.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			tx_pend    <= 1'b0;
			tx_pend_ep <= 1'b0;
		end else if (tx_start) begin
			tx_pend    <= 1'b1;
			tx_pend_ep <= tx_ep;
		end else if (host_ack || tok_valid) begin
			tx_pend <= 1'b0;
		end
	end

	// Receive sequencing: collect, drain the buffer into memory, then publish status.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			state       <= usb_ep_pkg::ST_IDLE;
			cur_setup   <= 1'b0;
			cur_store   <= 1'b0;
			pkt_err     <= 1'b0;
			pkt_crc_err <= 1'b0;
			pkt_pid_one <= 1'b0;
		end else begin
			case (state)
				usb_ep_pkg::ST_IDLE: begin
					if (tok0 && tok_type != usb_ep_pkg::TOK_IN) begin
						state     <= usb_ep_pkg::ST_RX_DATA;
						cur_setup <= setup0;
						cur_store <= setup0 || (accept && !stall0 && !auto_reply); // R8
					end
				end
				usb_ep_pkg::ST_RX_DATA: begin
					if (rx_end) begin
						state       <= usb_ep_pkg::ST_DRAIN;
						pkt_err     <= rx_err || rx_count > `MAX_RX_COUNT; // R10
						pkt_crc_err <= rx_err;
						pkt_pid_one <= rx_pid_one;
					end
				end
				usb_ep_pkg::ST_DRAIN: begin
					if (fifo_cnt == '0) begin
						state <= usb_ep_pkg::ST_UPDATE; // R1
					end
				end
				default: begin
					state <= usb_ep_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// Byte counters: received and drained bytes both saturate at 15; storing stops at eight.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			rx_count <= 4'h0;
			wr_idx   <= 4'h0;
		end else if (state == usb_ep_pkg::ST_IDLE) begin
			rx_count <= 4'h0;
			wr_idx   <= 4'h0;
		end else begin
			if (fifo_push && rx_count != `RX_COUNT_SAT) begin
				rx_count <= rx_count + 4'h1; // R6
			end
			if (fifo_pop && wr_idx != `RX_COUNT_SAT) begin
				wr_idx <= wr_idx + 4'h1;
			end
		end
	end

	// Two-entry buffer so a memory stall by firmware loses no received byte.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			fifo_wp  <= '0;
			fifo_rp  <= '0;
			fifo_cnt <= '0;
		end else begin
			if (fifo_push) begin
				fifo_mem[fifo_wp] <= rx_byte;
				fifo_wp <= (fifo_wp == PTR_W'(FIFO_DEPTH - 1)) ? '0 : fifo_wp + PTR_W'(1);
			end
			if (fifo_pop) begin
				fifo_rp <= (fifo_rp == PTR_W'(FIFO_DEPTH - 1)) ? '0 : fifo_rp + PTR_W'(1);
			end
			fifo_cnt <= fifo_cnt + CNT_W'(fifo_push) - CNT_W'(fifo_pop);
		end
	end

	// Endpoint buffers; endpoint zero shares its eight bytes for both directions.
	always_ff @(posedge core_clk) begin
		if (fw_buf_wr) begin
			ep_buf[buf_addr[3:0]] <= buf_wdata;
		end else if (fifo_pop && cur_store && wr_idx < `BUF_MAX_BYTES) begin
			ep_buf[{1'b0, wr_idx[2:0]}] <= fifo_mem[fifo_rp]; // R9 R23
		end
	end

	// Registered reads for firmware and for the transmitter.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			buf_rdata  <= `REG_RESET;
			tx_rd_data <= `REG_RESET;
		end else begin
			buf_rdata  <= fw_buf_hit ? ep_buf[buf_addr[3:0]] : `REG_RESET;
			tx_rd_data <= ep_buf[tx_rd_addr]; // R19
		end
	end

	// Endpoint-zero transmit configuration; hardware events win over a write.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			ep0_tx <= `REG_RESET;
		end else begin
			if (io_wr && io_addr == `EP0_TX_OFS) begin
				ep0_tx <= io_wdata;
			end
			if (state == usb_ep_pkg::ST_UPDATE && pkt_crc_err) begin
				ep0_tx[`TX_ERR_BIT] <= 1'b1; // R14
			end
			if (ack0) begin
				ep0_tx[`TX_ARMED_BIT] <= 1'b0; // R18
			end
			if (setup0) begin
				ep0_tx[`TX_STALL_BIT] <= 1'b0; // R15
				ep0_tx[`TX_ARMED_BIT] <= 1'b0; // R18
			end
		end
	end

	// Endpoint-one transmit configuration.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			ep1_tx <= `REG_RESET;
		end else begin
			if (io_wr && io_addr == `EP1_TX_OFS) begin
				ep1_tx <= io_wdata;
			end
			if (ack1) begin
				ep1_tx[`TX_ARMED_BIT] <= 1'b0; // R22
			end
		end
	end

	// Acceptance and auto reply bits; other bits of this register live elsewhere.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			usb_ctrl <= `REG_RESET;
		end else begin
			if (io_wr && io_addr == `USB_CTRL_OFS) begin
				usb_ctrl <= io_wdata & 8'h18;
			end
			if (setup0) begin
				usb_ctrl[`CTRL_AUTO_BIT] <= 1'b0; // R25
			end
			if (state == usb_ep_pkg::ST_UPDATE && (cur_setup || (next_hs == usb_ep_pkg::HS_ACK && !auto_reply))) begin
				usb_ctrl[`CTRL_ACCEPT_BIT] <= 1'b0; // R24
			end
		end
	end

	// Endpoint-zero receive status; a write clears all but the toggle and, during SETUP data, the SETUP flag.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			ep0_rx <= `REG_RESET;
		end else begin
			if (rx_write_hit) begin
				ep0_rx[7:4]           <= 4'h0; // R2
				ep0_rx[`RX_IN_BIT]    <= 1'b0;
				ep0_rx[`RX_OUT_BIT]   <= 1'b0;
				ep0_rx[`RX_SETUP_BIT] <= setup_locked && ep0_rx[`RX_SETUP_BIT]; // R3
			end
			if (tok0) begin
				ep0_rx[`RX_OUT_BIT] <= tok_type == usb_ep_pkg::TOK_OUT; // R4
				ep0_rx[`RX_IN_BIT]  <= tok_type == usb_ep_pkg::TOK_IN; // R4
			end
			if (setup0) begin
				ep0_rx[`RX_SETUP_BIT] <= 1'b1; // R3
			end
			if (state == usb_ep_pkg::ST_UPDATE && upd_toggle) begin
				ep0_rx[`RX_TOGGLE_BIT] <= pkt_pid_one; // R5
			end
			if (state == usb_ep_pkg::ST_UPDATE && upd_count) begin
				ep0_rx[7:4] <= rx_count; // R6 R7
			end
		end
	end

	// Events follow the status update by one cycle so firmware sees settled status.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			ev0_pend  <= 1'b0;
			ev1_pend  <= 1'b0;
			ep0_event <= 1'b0;
			ep1_event <= 1'b0;
		end else begin
			ev0_pend  <= (state == usb_ep_pkg::ST_UPDATE && upd_count) || ack0; // R1 R18
			ev1_pend  <= ack1; // R22
			ep0_event <= ev0_pend;
			ep1_event <= ev1_pend;
		end
	end

	// Register read mux.
	always_ff @(posedge core_clk) begin
		if (!resetn) begin
			io_rdata <= `REG_RESET;
		end else if (io_addr == `EP0_TX_OFS) begin
			io_rdata <= ep0_tx;
		end else if (io_addr == `EP1_TX_OFS) begin
			io_rdata <= ep1_tx;
		end else if (io_addr == `USB_CTRL_OFS) begin
			io_rdata <= usb_ctrl;
		end else if (io_addr == `EP0_RX_OFS) begin
			io_rdata <= ep0_rx;
		end else begin
			io_rdata <= `REG_RESET;
		end
	end

	status_then_event_a: assert property (@(posedge core_clk) disable iff (!resetn) // R1
		state == usb_ep_pkg::ST_UPDATE && upd_count |-> !ep0_event ##2 ep0_event)
		else $error("event did not follow status update");
	rx_write_clear_a: assert property (@(posedge core_clk) disable iff (!resetn) // R2
		rx_write_hit && !tok_valid && state == usb_ep_pkg::ST_IDLE |=> ep0_rx[7:4] == 4'h0 && ep0_rx[2:0] == 3'h0
		&& ep0_rx[`RX_TOGGLE_BIT] == $past(ep0_rx[`RX_TOGGLE_BIT]))
		else $error("status write did not clear");
	setup_flag_a: assert property (@(posedge core_clk) disable iff (!resetn) // R3
		setup0 |=> ep0_rx[`RX_SETUP_BIT] && !ep0_tx[`TX_STALL_BIT] && !ep0_tx[`TX_ARMED_BIT])
		else $error("setup token effects missing");
	token_flags_a: assert property (@(posedge core_clk) disable iff (!resetn) // R4
		tok0 && tok_type == usb_ep_pkg::TOK_IN |=> ep0_rx[`RX_IN_BIT] && !ep0_rx[`RX_OUT_BIT])
		else $error("token flags wrong");
	error_silent_a: assert property (@(posedge core_clk) disable iff (!resetn) // R10
		state == usb_ep_pkg::ST_UPDATE && pkt_err |=> !hs_valid)
		else $error("handshake sent for bad packet");
	ep0_stall_a: assert property (@(posedge core_clk) disable iff (!resetn) // R15
		tok0 && tok_type == usb_ep_pkg::TOK_IN && stall0 && state != usb_ep_pkg::ST_UPDATE
		|=> hs_valid && hs_code == usb_ep_pkg::HS_STALL && !tx_start)
		else $error("stalled IN not stalled");
	armed_only_a: assert property (@(posedge core_clk) disable iff (!resetn) // R17
		tx_start |-> (tx_ep ? $past(ep1_tx[`TX_ARMED_BIT]) : $past(ep0_tx[`TX_ARMED_BIT])))
		else $error("data sent while not armed");
	ack_disarm_a: assert property (@(posedge core_clk) disable iff (!resetn) // R18
		ack0 && !setup0 |=> !ep0_tx[`TX_ARMED_BIT] ##1 ep0_event)
		else $error("ack did not disarm endpoint zero");
	ep1_ignore_a: assert property (@(posedge core_clk) disable iff (!resetn) // R20
		tok_valid && tok_ep && !ep1_tx[`TX_EP1_ON_BIT] && state != usb_ep_pkg::ST_UPDATE |=> !hs_valid && !tx_start)
		else $error("disabled endpoint one answered");

endmodule

// ### hw/usb_ep_consts.svh
`ifndef USB_EP_CONSTS_SVH
`define USB_EP_CONSTS_SVH

// I/O offsets of the endpoint registers.
`define EP0_TX_OFS      8'h10
`define EP1_TX_OFS      8'h11
`define USB_CTRL_OFS    8'h13
`define EP0_RX_OFS      8'h14

// Endpoint buffers occupy data memory 0x70 to 0x7F; upper nibble selects them.
`define BUF_REGION      4'h7

// Transmit configuration fields.
`define TX_ERR_BIT      4
`define TX_EP1_ON_BIT   4
`define TX_STALL_BIT    5
`define TX_PID_BIT      6
`define TX_ARMED_BIT    7

// Endpoint-zero receive status fields.
`define RX_SETUP_BIT    0
`define RX_OUT_BIT      1
`define RX_IN_BIT       2
`define RX_TOGGLE_BIT   3

// Control register fields kept by this block.
`define CTRL_AUTO_BIT   3
`define CTRL_ACCEPT_BIT 4

// Reset value of every register.
`define REG_RESET       8'h00

// Byte limits: eight stored bytes, two CRC bytes, ten bytes the most a packet may carry.
`define BUF_MAX_BYTES   4'h8
`define CRC_BYTES       4'h2
`define MAX_RX_COUNT    4'hA
`define RX_COUNT_SAT    4'hF

`endif

// ### hw/usb_ep_pkg.sv
package usb_ep_pkg;

	// Token kinds decoded by the bus protocol engine.
	typedef enum logic [1:0] {TOK_OUT, TOK_IN, TOK_SETUP} tok_t;

	// Handshake the engine is told to send.
	typedef enum logic [1:0] {HS_NONE, HS_ACK, HS_NAK, HS_STALL} hs_t;

	// Receive sequencing of endpoint zero.
	typedef enum logic [1:0] {ST_IDLE, ST_RX_DATA, ST_DRAIN, ST_UPDATE} state_t;

endpackage

// ### tb/usb_host_model.sv
`timescale 1ns/10ps
// Far side of the block: issues tokens, streams packet bytes and acknowledges data.
module usb_host_model (
	// Clock.
	input  wire logic        core_clk,
	// Tokens.
	output logic             tok_valid,
	output usb_ep_pkg::tok_t tok_type,
	output logic             tok_ep,
	// Received packet stream.
	output logic             rx_byte_valid,
	output logic [7:0]       rx_byte,
	input  wire logic        rx_byte_ready,
	output logic             rx_end,
	output logic             rx_err,
	output logic             rx_pid_one,
	// Transmit fetch and acknowledge.
	input  wire logic        tx_start,
	output logic [3:0]       tx_rd_addr,
	input  wire logic [7:0]  tx_rd_data,
	output logic             host_ack
);
	// Idle levels at time zero.
	initial begin
		tok_valid = 1'b0;
		tok_type = usb_ep_pkg::TOK_OUT;
		tok_ep = 1'b0;
		rx_byte_valid = 1'b0;
		rx_byte = 8'h00;
		rx_end = 1'b0;
		rx_err = 1'b0;
		rx_pid_one = 1'b0;
		tx_rd_addr = 4'h0;
		host_ack = 1'b0;
	end

	// One token pulse; the endpoint line is inverted afterwards so no stale value lingers.
	task automatic token(input usb_ep_pkg::tok_t t, input logic ep);
		@(posedge core_clk) #1;
		tok_valid = 1'b1;
		tok_type = t;
		tok_ep = ep;
		@(posedge core_clk) #1;
		tok_valid = 1'b0;
		tok_ep = ~ep;
	endtask

	// Bytes are held until taken; a gap makes the sender slow instead of prompt.
	task automatic packet(input logic [7:0] pq[$], input logic e, input logic p, input int gap);
		foreach (pq[i]) begin
			rx_byte_valid = 1'b1;
			rx_byte = pq[i];
			do @(negedge core_clk); while (rx_byte_ready !== 1'b1);
			@(posedge core_clk) #1;
			if (gap > 0) begin
				rx_byte_valid = 1'b0;
				rx_byte = ~rx_byte;
				repeat (gap) @(posedge core_clk);
				#1;
			end
		end
		rx_byte_valid = 1'b0;
		rx_byte = ~rx_byte;
		@(posedge core_clk) #1;
		rx_end = 1'b1;
		rx_err = e;
		rx_pid_one = p;
		@(posedge core_clk) #1;
		rx_end = 1'b0;
		rx_err = ~e;
		rx_pid_one = ~p;
	endtask

	// IN transaction: fetch the first byte and acknowledge only if data was sent.
	task automatic in_txn(input logic ep, output logic [7:0] b, output bit got);
		got = 1'b0;
		b = 8'h00;
		token(usb_ep_pkg::TOK_IN, ep);
		repeat (3) begin
			@(posedge core_clk);
			if (tx_start === 1'b1) got = 1'b1;
		end
		#1;
		if (got) begin
			tx_rd_addr = {ep, 3'b000};
			@(posedge core_clk) #1;
			b = tx_rd_data;
			tx_rd_addr = ~tx_rd_addr;
			host_ack = 1'b1;
			@(posedge core_clk) #1;
			host_ack = 1'b0;
		end
	endtask
endmodule

// ### tb/testbench.sv
`timescale 1ns/10ps
module testbench;
	// Firmware-side drive.
	logic             core_clk = 1'b0;
	logic             resetn = 1'b0;
	logic [7:0]       io_addr = 8'h00;
	logic [7:0]       io_wdata = 8'h00;
	logic [7:0]       buf_addr = 8'h00;
	logic [7:0]       buf_wdata = 8'h00;
	logic             io_wr = 1'b0;
	logic             buf_wr = 1'b0;
	// Design outputs and partner wires.
	logic [7:0]       io_rdata, buf_rdata, rx_byte, tx_rd_data;
	logic             tok_valid, tok_ep, rx_byte_valid, rx_byte_ready, rx_end, rx_err, rx_pid_one;
	logic             hs_valid, tx_start, tx_ep, tx_pid_one, host_ack, ep0_event, ep1_event;
	logic [3:0]       tx_len, tx_rd_addr, tlen;
	usb_ep_pkg::tok_t tok_type;
	usb_ep_pkg::hs_t  hs_code, hs_last;
	// Counters and reference model state.
	int               err_total = 0;
	int               checks_done = 0;
	int               cyc = 0;
	int               hs_n, ev0_n, ev1_n, tx_n, stall_n;
	logic [7:0]       m_mem[16], q[$], d, b;
	logic [7:0]       arx[3] = '{8'h2A, 8'h3A, 8'h32};
	logic [7:0]       addrs[5] = '{8'h10, 8'h11, 8'h13, 8'h14, 8'h20};
	logic             tep, tpid;
	bit               got;

	lowspeed_usb_endpoint_ctrl dut_u (.core_clk, .resetn, .io_addr, .io_wr, .io_wdata, .io_rdata, .buf_addr,
		.buf_wr, .buf_wdata, .buf_rdata, .tok_valid, .tok_type, .tok_ep, .rx_byte_valid, .rx_byte,
		.rx_byte_ready, .rx_end, .rx_err, .rx_pid_one, .hs_valid, .hs_code, .tx_start, .tx_ep,
		.tx_pid_one, .tx_len, .tx_rd_addr, .tx_rd_data, .host_ack, .ep0_event, .ep1_event);
	usb_host_model host_u (.core_clk, .tok_valid, .tok_type, .tok_ep, .rx_byte_valid, .rx_byte,
		.rx_byte_ready, .rx_end, .rx_err, .rx_pid_one, .tx_start, .tx_rd_addr, .tx_rd_data, .host_ack);

	// 50 MHz clock.
	always #10 core_clk = ~core_clk;

	// Pulses are counted at the edge, before that edge's updates land; the cycle ceiling cuts hangs.
	always @(posedge core_clk) begin
		cyc = cyc + 1;
		if (hs_valid === 1'b1) begin
			hs_n = hs_n + 1;
			hs_last = hs_code;
		end
		if (ep0_event === 1'b1) ev0_n = ev0_n + 1;
		if (ep1_event === 1'b1) ev1_n = ev1_n + 1;
		if (tx_start === 1'b1) begin
			tx_n = tx_n + 1;
			tep = tx_ep;
			tpid = tx_pid_one;
			tlen = tx_len;
		end
		if (rx_byte_valid === 1'b1 && rx_byte_ready === 1'b0) stall_n = stall_n + 1;
		if (cyc == 5000) begin
			err_total = err_total + 1;
			complete_run();
		end
	end

	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checks_done = checks_done + 1;
		if (g !== e) begin
			err_total = err_total + 1;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge core_clk) #1;
		io_addr = a;
		io_wdata = v;
		io_wr = 1'b1;
		@(posedge core_clk) #1;
		io_wr = 1'b0;
	endtask

	// Register read: the answer is registered one edge after the address.
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		@(posedge core_clk) #1;
		io_addr = a;
		@(posedge core_clk) #1;
		chk("register", e, io_rdata);
	endtask

	task automatic bwr(input logic [7:0] a, input logic [7:0] v);
		@(posedge core_clk) #1;
		buf_addr = a;
		buf_wdata = v;
		buf_wr = 1'b1;
		@(posedge core_clk) #1;
		buf_wr = 1'b0;
	endtask

	task automatic bchk(input logic [7:0] a, input logic [7:0] e);
		@(posedge core_clk) #1;
		buf_addr = a;
		@(posedge core_clk) #1;
		chk("buffer", e, buf_rdata);
	endtask

	// Compares the whole endpoint-zero buffer with the model.
	task automatic mem_chk;
		for (int i = 0; i < 8; i++) begin
			bchk(8'(8'h70 + i), m_mem[i]);
		end
	endtask

	task automatic clr;
		hs_n = 0;
		ev0_n = 0;
		ev1_n = 0;
		tx_n = 0;
	endtask

	// Endpoint-zero transfer with random payload; the last two bytes play the CRC.
	task automatic pkt(input usb_ep_pkg::tok_t t, input int n, input logic e, input logic p, input int gap);
		q.delete();
		repeat (n) q.push_back(8'($urandom));
		host_u.token(t, 1'b0);
		host_u.packet(q, e, p, gap);
	endtask

	// Long enough for drain, update and event; a negative count skips the handshake check.
	task automatic settle(input int hs, input usb_ep_pkg::hs_t c, input int e0);
		repeat (12) @(posedge core_clk);
		#1;
		if (hs >= 0) chk("handshakes", 8'(hs), 8'(hs_n));
		if (hs > 0) chk("hs_code", 8'(c), 8'(hs_last));
		chk("ep0 events", 8'(e0), 8'(ev0_n));
	endtask

	task automatic tend(input string n);
		$display("test %s done", n);
	endtask

	task automatic complete_run;
		$display("checks_done %0d err_total %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	initial begin
		void'($urandom(32'hF37A));
		repeat (20) @(posedge core_clk);
		#1;
		resetn = 1'b1;
		foreach (addrs[i]) rchk(addrs[i], 8'h00);
		tend("reset");
		// SETUP clears stall, armed, auto reply and acceptance, and stores despite them.
		wr(8'h10, 8'hA3);
		wr(8'h13, 8'h18);
		clr();
		pkt(usb_ep_pkg::TOK_SETUP, 8, 1'b0, 1'b1, 0);
		settle(1, usb_ep_pkg::HS_ACK, 1);
		rchk(8'h14, {4'd8, 1'b1, 3'b001});
		rchk(8'h10, 8'h03);
		rchk(8'h13, 8'h00);
		foreach (q[i]) m_mem[i] = q[i];
		mem_chk();
		bwr(8'h70, ~q[0]);
		bchk(8'h70, q[0]);
		wr(8'h14, 8'hFF);
		rchk(8'h14, 8'h08);
		tend("setup");
		// Stalled OUT, then idle OUT: neither stores nor interrupts; slow sender.
		for (int s = 1; s >= 0; s--) begin
			wr(8'h10, {2'b00, s[0], 5'h00});
			clr();
			pkt(usb_ep_pkg::TOK_OUT, 3, 1'b0, 1'b0, 2);
			settle(1, s ? usb_ep_pkg::HS_STALL : usb_ep_pkg::HS_NAK, 0);
			rchk(8'h14, 8'h0A);
			rchk(8'h13, 8'h00);
		end
		mem_chk();
		tend("nak_stall");
		// Accepted OUT of ten bytes while firmware writes hold the drain and fill the buffer.
		wr(8'h13, 8'h10);
		clr();
		stall_n = 0;
		fork
			pkt(usb_ep_pkg::TOK_OUT, 10, 1'b0, 1'b0, 0);
			begin
				repeat (4) @(posedge core_clk);
				#1;
				buf_addr = 8'h7F;
				buf_wdata = 8'hA5;
				buf_wr = 1'b1;
				repeat (4) @(posedge core_clk);
				#1;
				buf_wr = 1'b0;
			end
		join
		settle(1, usb_ep_pkg::HS_ACK, 1);
		chk("drain stall", 8'h01, 8'(stall_n > 0));
		rchk(8'h14, {4'd10, 1'b0, 3'b010});
		rchk(8'h13, 8'h00);
		for (int i = 0; i < 8; i++) m_mem[i] = q[i];
		mem_chk();
		bchk(8'h7F, 8'hA5);
		tend("accept");
		// Auto reply: status OUT, other OUT, then an errored OUT.
		wr(8'h13, 8'h08);
		for (int k = 0; k < 3; k++) begin
			clr();
			pkt(usb_ep_pkg::TOK_OUT, 2 + (k == 1), k == 2, k < 2, k);
			settle(k < 2, k ? usb_ep_pkg::HS_STALL : usb_ep_pkg::HS_ACK, k < 2);
			rchk(8'h14, arx[k]);
		end
		mem_chk();
		rchk(8'h10, 8'h10);
		rchk(8'h13, 8'h08);
		tend("auto_reply");
		// Armed IN on endpoint zero, then an unarmed one.
		wr(8'h10, 8'hC5);
		clr();
		host_u.in_txn(1'b0, b, got);
		settle(-1, usb_ep_pkg::HS_NONE, 1);
		chk("tx count", 8'h01, 8'(tx_n));
		chk("tx frame", {2'b00, tep, tpid, tlen}, {2'b00, 1'b0, 1'b1, 4'd5});
		chk("tx byte", m_mem[0], b);
		rchk(8'h10, 8'h45);
		rchk(8'h14, 8'h34);
		clr();
		host_u.in_txn(1'b0, b, got);
		settle(-1, usb_ep_pkg::HS_NONE, 0);
		chk("unarmed tx", 8'h00, 8'(tx_n));
		wr(8'h10, 8'h20);
		clr();
		host_u.token(usb_ep_pkg::TOK_IN, 1'b0);
		settle(1, usb_ep_pkg::HS_STALL, 0);
		tend("ep0_in");
		// Endpoint one: ignored while off, then sent, then stalled both ways.
		d = 8'($urandom);
		bwr(8'h78, d);
		wr(8'h11, 8'hC8);
		clr();
		host_u.in_txn(1'b1, b, got);
		settle(0, usb_ep_pkg::HS_NONE, 0);
		chk("ep1 off", 8'h00, 8'(tx_n));
		wr(8'h11, 8'hD8);
		clr();
		host_u.in_txn(1'b1, b, got);
		settle(-1, usb_ep_pkg::HS_NONE, 0);
		chk("tx frame", {2'b00, tep, tpid, tlen}, {2'b00, 1'b1, 1'b1, 4'd8});
		chk("tx byte", d, b);
		chk("ep1 events", 8'h01, 8'(ev1_n));
		rchk(8'h11, 8'h58);
		wr(8'h11, 8'h30);
		for (int t = 0; t < 2; t++) begin
			clr();
			host_u.token(t ? usb_ep_pkg::TOK_OUT : usb_ep_pkg::TOK_IN, 1'b1);
			settle(1, usb_ep_pkg::HS_STALL, 0);
		end
		rchk(8'h14, 8'h34);
		tend("ep1");
		complete_run();
	end
endmodule
